// ==== fdh_pkg.sv ====
// Package of constants and types for the flash disk host port controller
package fdh_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 512;
  localparam int SIG_BYTES = 6;
  localparam int SYM_BITS = 10;
  localparam int FIFO_DEPTH = 16;
  // Strobe timing, in ns, and derived cycle counts at 10 MHz
  localparam int CLK_NS = 100;
  localparam int SETUP_NS = 100;
  localparam int STROBE_NS = 200;
  localparam int HOLD_NS = 100;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  // Window locations; the controller itself uses only CTRL_ADDR and DATA_ADDR
  localparam logic [12:0] CTRL_ADDR = 13'h1002;
  localparam logic [12:0] STATUS_ADDR = 13'h1004;
  localparam logic [12:0] DATA_ADDR = 13'h1800;
  localparam logic [12:0] SIG_ADDR = 13'h1008;
  localparam logic [7:0] LEAVE_RST_1 = 8'h0D;
  localparam logic [7:0] LEAVE_RST_2 = 8'h0D;
  localparam int READY_BIT = 7;
  typedef enum logic [1:0] {FDH_CMD_RD, FDH_CMD_WR, FDH_CMD_WAKE, FDH_CMD_PAGE} fdh_cmd_e;
endpackage

// ==== fdh_stream_if.sv ====
// Interface carrying the data stream between controller and its FIFO
`timescale 1ns/1ns
interface fdh_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== fdh_fifo.sv ====
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ns
module fdh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  fdh_stream_if.snk in_s,
  fdh_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_s.ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_reg != '0);
  assign out_s.data = mem_reg[rd_ptr_reg];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_s.data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
  property p_no_overflow;
    @(posedge clk) disable iff (rst)
    cnt_reg <= (AW+1)'(DEPTH);
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo count exceeds depth");
endmodule

// ==== fdh_host.sv ====
// Host-side controller driving the flash disk memory window pins
`timescale 1ns/1ns
// Notes on behaviour
// - Host drives 13-bit window address each access
// - Write needs chip select and write low
// - Read needs chip select and output low
// - Strobes active low; high releases them
// - Host software corrects using the signature
// - Code uses 10-bit symbols, two correctable
// - Control register write sequence changes mode
module fdh_host
  import fdh_pkg::*;
#(
  parameter int FIFO_W = DATA_W,
  parameter int FIFO_D = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  input wire logic rd_ready,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output logic page_busy,
  output logic [ADDR_W-1:0] dev_addr,
  input wire logic [DATA_W-1:0] dev_data_in,
  output logic [DATA_W-1:0] dev_data_out,
  output logic dev_data_oe_n,
  output logic dev_ce_n,
  output logic dev_oe_n,
  output logic dev_we_n
);
  // ****************************************************************
  // Pin sampling and stream
  // ****************************************************************
  logic [DATA_W-1:0] din_meta_reg;
  logic [DATA_W-1:0] din_sync_reg;
  fdh_stream_if #(.W(FIFO_W)) fill_s ();
  fdh_stream_if #(.W(FIFO_W)) drain_s ();
  fdh_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_s(fill_s),
    .out_s(drain_s)
  );
  assign rd_valid = drain_s.valid;
  assign rd_data = drain_s.data;
  assign drain_s.ready = rd_ready;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      din_meta_reg <= '0;
      din_sync_reg <= '0;
    end else begin
      din_meta_reg <= dev_data_in;
      din_sync_reg <= din_meta_reg;
    end
  end
  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  typedef enum logic [2:0] {FDH_IDLE, FDH_SETUP, FDH_STROBE, FDH_SAMPLE, FDH_HOLD, FDH_PUSH}
    fdh_state_e;
  fdh_state_e state_reg;
  logic [3:0] cnt_reg;
  logic is_write_reg;
  logic page_mode_reg;
  logic [9:0] page_left_reg;
  logic [1:0] wake_left_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] last_rd_reg;
  function automatic logic is_wr_op(input logic [1:0] op);
    return (op == FDH_CMD_WR) || (op == FDH_CMD_WAKE);
  endfunction
  assign cmd_ready = (state_reg == FDH_IDLE) && !page_mode_reg && (wake_left_reg == 2'd0);
  assign page_busy = page_mode_reg;
  assign fill_s.data = last_rd_reg;
  assign fill_s.valid = (state_reg == FDH_PUSH);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= FDH_IDLE;
      cnt_reg <= '0;
      is_write_reg <= 1'b0;
      page_mode_reg <= 1'b0;
      page_left_reg <= '0;
      wake_left_reg <= '0;
      wdata_reg <= '0;
      last_rd_reg <= '0;
      dev_addr <= '0;
      dev_data_out <= '0;
      dev_data_oe_n <= 1'b1;
      dev_ce_n <= 1'b1;
      dev_oe_n <= 1'b1;
      dev_we_n <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        FDH_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            dev_addr <= cmd_addr;
            is_write_reg <= is_wr_op(cmd_op);
            case (cmd_op)
              FDH_CMD_WAKE: begin
                // Leave-reset sequence: two control writes
                dev_addr <= CTRL_ADDR;
                wdata_reg <= LEAVE_RST_1;
                wake_left_reg <= 2'd1;
              end
              FDH_CMD_PAGE: begin
                // Device signs each page on the fly; host just streams it
                dev_addr <= DATA_ADDR;
                page_mode_reg <= 1'b1;
                page_left_reg <= 10'(PAGE_BYTES);
              end
              default: wdata_reg <= cmd_wdata;
            endcase
            cnt_reg <= 4'(SETUP_CYC);
            state_reg <= FDH_SETUP;
          end else if (wake_left_reg != 2'd0) begin
            dev_addr <= CTRL_ADDR;
            wdata_reg <= LEAVE_RST_2;
            is_write_reg <= 1'b1;
            wake_left_reg <= 2'd0;
            cnt_reg <= 4'(SETUP_CYC);
            state_reg <= FDH_SETUP;
          end else if (page_mode_reg) begin
            if (page_left_reg == 10'd0) begin
              page_mode_reg <= 1'b0;
            end else if (fill_s.ready) begin
              dev_addr <= DATA_ADDR;
              is_write_reg <= 1'b0;
              cnt_reg <= 4'(SETUP_CYC);
              state_reg <= FDH_SETUP;
            end
          end
        end
        FDH_SETUP: begin
          if (is_write_reg) begin
            dev_data_out <= wdata_reg;
            dev_data_oe_n <= 1'b0;
          end
          if (cnt_reg <= 4'd1) begin
            dev_ce_n <= 1'b0;
            dev_we_n <= !is_write_reg;
            dev_oe_n <= is_write_reg;
            cnt_reg <= 4'(STROBE_CYC);
            state_reg <= FDH_STROBE;
          end else begin
            cnt_reg <= cnt_reg - 4'd1;
          end
        end
        FDH_STROBE: begin
          // Device is clockless, so strobe width alone times the access
          if (cnt_reg <= 4'd1) begin
            state_reg <= FDH_SAMPLE;
          end else begin
            cnt_reg <= cnt_reg - 4'd1;
          end
        end
        FDH_SAMPLE: begin
          // Two extra cycles cover the data synchroniser
          if (cnt_reg == 4'd2) begin
            last_rd_reg <= din_sync_reg;
            dev_ce_n <= 1'b1;
            dev_oe_n <= 1'b1;
            dev_we_n <= 1'b1;
            cnt_reg <= 4'(HOLD_CYC);
            state_reg <= FDH_HOLD;
          end else begin
            cnt_reg <= cnt_reg + 4'd1;
          end
        end
        FDH_HOLD: begin
          if (cnt_reg <= 4'd1) begin
            dev_data_oe_n <= 1'b1;
            if (page_mode_reg) begin
              state_reg <= FDH_PUSH;
            end else begin
              rsp_valid <= 1'b1;
              // Signature bytes reach software here; correction stays in software
              rsp_data <= last_rd_reg;
              state_reg <= FDH_IDLE;
            end
          end else begin
            cnt_reg <= cnt_reg - 4'd1;
          end
        end
        FDH_PUSH: begin
          if (fill_s.ready) begin
            page_left_reg <= page_left_reg - 10'd1;
            state_reg <= FDH_IDLE;
          end
        end
        default: state_reg <= FDH_IDLE;
      endcase
    end
  end
  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_wr_strobe;
    @(posedge clk) disable iff (rst)
    !dev_we_n |-> !dev_ce_n && dev_oe_n && !dev_data_oe_n;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("bad write strobe");

  property p_rd_strobe;
    @(posedge clk) disable iff (rst)
    !dev_oe_n |-> !dev_ce_n && dev_we_n && dev_data_oe_n;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("bad read strobe");

  property p_strobe_width;
    @(posedge clk) disable iff (rst)
    $fell(dev_ce_n) |-> !dev_ce_n [*3];
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe too short");

  property p_release;
    @(posedge clk) disable iff (rst)
    $rose(dev_ce_n) |-> dev_we_n && dev_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("strobe left asserted");

  property p_addr_stable;
    @(posedge clk) disable iff (rst)
    !dev_ce_n |=> $stable(dev_addr) || dev_ce_n;
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in access");

  property p_wake_second;
    @(posedge clk) disable iff (rst)
    (state_reg == FDH_IDLE && wake_left_reg == 2'd1) |=>
      wake_left_reg == 2'd0 && dev_addr == CTRL_ADDR;
  endproperty
  a_wake_second: assert property (p_wake_second) else $error("leave sequence incomplete");

  property p_page_addr;
    @(posedge clk) disable iff (rst)
    (page_mode_reg && !dev_ce_n) |-> dev_addr == DATA_ADDR;
  endproperty
  a_page_addr: assert property (p_page_addr) else $error("page read off data port");

  property p_rsp;
    @(posedge clk) disable iff (rst)
    rsp_valid |-> $past(state_reg) == FDH_HOLD;
  endproperty
  a_rsp: assert property (p_rsp) else $error("response out of sequence");

  // Idle means the pins are quiet, so a new command never lands mid-cycle
  property p_cmd_quiet;
    @(posedge clk) disable iff (rst)
    cmd_ready |-> dev_ce_n && dev_data_oe_n;
  endproperty
  a_cmd_quiet: assert property (p_cmd_quiet) else $error("pins busy while idle");

  property p_data_release;
    @(posedge clk) disable iff (rst)
    $rose(dev_data_oe_n) |-> dev_ce_n && dev_we_n;
  endproperty
  a_data_release: assert property (p_data_release) else $error("data dropped in write");

  property p_addr_hold;
    @(posedge clk) disable iff (rst)
    $rose(dev_ce_n) |-> $stable(dev_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved at release");

  property p_sample_in_strobe;
    @(posedge clk) disable iff (rst)
    (state_reg == FDH_SAMPLE && cnt_reg == 4'd2) |-> !dev_ce_n;
  endproperty
  a_sample_in_strobe: assert property (p_sample_in_strobe) else $error("late sample");

  property p_page_stall;
    @(posedge clk) disable iff (rst)
    (state_reg == FDH_IDLE && page_mode_reg && !fill_s.ready) |=> dev_ce_n;
  endproperty
  a_page_stall: assert property (p_page_stall) else $error("page read into full fifo");

  property p_cmd_take;
    @(posedge clk) disable iff (rst)
    (cmd_valid && cmd_ready) |=> state_reg == FDH_SETUP;
  endproperty
  a_cmd_take: assert property (p_cmd_take) else $error("command not started");

  property p_wr_data;
    @(posedge clk) disable iff (rst)
    !dev_data_oe_n |-> dev_data_out == wdata_reg;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data moved");
endmodule

// ==== fdh_dev_model.sv ====
// Behavioural model of the clockless flash disk window behind the host port
`timescale 1ns/1ns
module fdh_dev_model
  import fdh_pkg::*;
#(
  parameter logic [7:0] FIXED_RD = 8'h5A
) (
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic normal_mode;
  logic [1:0] wake_cnt;
  logic [9:0] page_ptr;
  logic [7:0] last_q;
  logic [7:0] rd_val;
  logic rd_act;
  logic wr_act;
  // No clock: strobe pairs alone frame each cycle
  assign rd_act = !ce_n && !oe_n;
  assign wr_act = !ce_n && !we_n;
  always_comb begin
    rd_val = 8'h00;
    if (!normal_mode) rd_val = FIXED_RD;
    else if (addr == STATUS_ADDR) rd_val[READY_BIT] = 1'b1;
    else if (addr == DATA_ADDR) rd_val = page_ptr[7:0];
    else rd_val = mem[addr];
  end
  // Released bus shows the inverse of the last byte, never a stale copy
  assign dq_out = rd_act ? rd_val : ~last_q;
  initial begin
    normal_mode = 1'b0;
    wake_cnt = 2'h0;
    page_ptr = 10'h000;
    last_q = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  always @(negedge rd_act) begin
    last_q = rd_val;
    if (normal_mode && addr == DATA_ADDR) page_ptr = page_ptr + 10'h001;
  end
  always @(negedge wr_act) begin
    if (normal_mode) mem[addr] = dq_in;
    else if (addr == CTRL_ADDR && dq_in == LEAVE_RST_1 && wake_cnt == 2'h0) wake_cnt = 2'h1;
    else if (addr == CTRL_ADDR && dq_in == LEAVE_RST_2 && wake_cnt == 2'h1) normal_mode = 1'b1;
    else wake_cnt = 2'h0;
  end
endmodule

// ==== tb_fdh_host.sv ====
// Self-checking testbench for the flash disk host port controller
`timescale 1ns/1ns
module tb_fdh_host;
  import fdh_pkg::*;
  localparam logic [7:0] FIXED_RD = 8'h5A;
  logic clk, rst, cmd_valid, cmd_ready, rsp_valid, rd_ready, rd_valid, page_busy;
  logic [1:0] cmd_op;
  logic [ADDR_W-1:0] cmd_addr, dev_addr;
  logic [7:0] cmd_wdata, rsp_data, rd_data, dev_data_out, dev_q;
  logic dev_data_oe_n, dev_ce_n, dev_oe_n, dev_we_n;
  wire logic [7:0] dev_data_in;
  int mismatches = 0;
  int comparisons = 0;
  int rd_cnt = 0;
  assign dev_data_in = !dev_data_oe_n ? dev_data_out : dev_q;
  fdh_host #(.FIFO_W(DATA_W), .FIFO_D(FIFO_DEPTH)) dut (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rd_ready(rd_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .page_busy(page_busy), .dev_addr(dev_addr),
    .dev_data_in(dev_data_in), .dev_data_out(dev_data_out), .dev_data_oe_n(dev_data_oe_n),
    .dev_ce_n(dev_ce_n), .dev_oe_n(dev_oe_n), .dev_we_n(dev_we_n));
  fdh_dev_model #(.FIXED_RD(FIXED_RD)) model (.addr(dev_addr), .dq_in(dev_data_in),
    .dq_out(dev_q), .ce_n(dev_ce_n), .oe_n(dev_oe_n), .we_n(dev_we_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic do_cmd(input logic [1:0] op, input logic [12:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    int n;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    chk1(cmd_ready, 1'b1, "command refused");
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    q = 8'h00;
    if (op == FDH_CMD_PAGE) return;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1 n++;
    end
    chk1(rsp_valid, 1'b1, "no response");
    q = rsp_data;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    chk1(dev_ce_n & dev_oe_n & dev_we_n, 1'b1, "strobe low after reset");
    chk1(dev_data_oe_n, 1'b1, "data driven after reset");
    chk1(cmd_ready, 1'b1, "not ready after reset");
    $display("test reset done");
  endtask
  task automatic t_rst_mode();
    logic [7:0] q;
    do_cmd(FDH_CMD_RD, 13'h0010, 8'h00, q);
    chk8(q, FIXED_RD, "reset mode read");
    do_cmd(FDH_CMD_WR, 13'h0010, 8'h3C, q);
    do_cmd(FDH_CMD_RD, STATUS_ADDR, 8'h00, q);
    chk8(q, FIXED_RD, "reset mode status");
    do_cmd(FDH_CMD_WAKE, CTRL_ADDR, 8'h00, q);
    do_cmd(FDH_CMD_RD, 13'h0010, 8'h00, q);
    chk8(q, 8'h00, "write kept in reset mode");
    do_cmd(FDH_CMD_RD, STATUS_ADDR, 8'h00, q);
    chk1(q[READY_BIT], 1'b1, "status not ready");
    $display("test reset mode and wake done");
  endtask
  task automatic t_normal();
    logic [7:0] q;
    logic [12:0] a [3] = '{13'h0000, 13'h1FFF, 13'h0555};
    logic [7:0] d [3] = '{8'hA5, 8'h5A, 8'hC3};
    for (int i = 0; i < 3; i++) do_cmd(FDH_CMD_WR, a[i], d[i], q);
    for (int i = 0; i < 3; i++) begin
      do_cmd(FDH_CMD_RD, a[i], 8'h00, q);
      chk8(q, d[i], "read back");
    end
    $display("test normal access done");
  endtask
  task automatic t_page();
    logic [7:0] q;
    int n;
    int base;
    base = rd_cnt;
    rd_ready = 1'b0;
    do_cmd(FDH_CMD_PAGE, DATA_ADDR, 8'h00, q);
    repeat (400) @(posedge clk);
    #1 chk1(page_busy, 1'b1, "page not busy");
    chk1(cmd_ready, 1'b0, "command taken mid page");
    chk1(rd_cnt - base == FIFO_DEPTH, 1'b1, "reads not stopped at full fifo");
    rd_ready = 1'b1;
    for (int k = 0; k < PAGE_BYTES; k++) begin
      n = 0;
      while (rd_valid !== 1'b1 && n < 50) begin
        @(posedge clk);
        #1 n++;
      end
      chk1(rd_valid, 1'b1, "page byte missing");
      chk8(rd_data, k[7:0], "page byte");
      @(posedge clk);
      #1;
    end
    repeat (12) @(posedge clk);
    #1 chk1(page_busy | rd_valid, 1'b0, "page not finished");
    $display("test page read done");
  endtask
  // Pin protocol watched mid-cycle, where the pins have settled
  always @(negedge clk) if (!rst) begin
    if (dev_oe_n === 1'b0) chk1(dev_data_oe_n, 1'b1, "host drives during read");
    if (dev_we_n === 1'b0) chk1(dev_ce_n | dev_data_oe_n, 1'b0, "bad write cycle");
  end
  always @(negedge dev_oe_n) if (!rst) rd_cnt++;
  initial begin
    #3000000;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_addr = 13'h0000;
    cmd_wdata = 8'h00;
    rd_ready = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_rst_mode();
    t_normal();
    t_page();
    wrap_up();
  end
endmodule
